// file: verilog/temp_alert_pkg.sv
// Purpose: Shared constants and types for the temperature result and
//          alert compare block.
// Assumes: APB slave with 32-bit data, word-aligned registers.
// Notes:   Limits and results are 16-bit left-justified two's complement.

package temp_alert_pkg;

    // ************************************************************
    // Widths
    // ************************************************************
    localparam int TEMP_W = 14;
    localparam int DATA_W = 16;
    localparam int CHANNELS = 2;

    // ************************************************************
    // Register byte offsets
    // ************************************************************
    localparam logic [7:0] OFS_TEMP = 8'h00;
    localparam logic [7:0] OFS_CONFIG = 8'h04;
    localparam logic [7:0] OFS_HIGH_ONE = 8'h08;
    localparam logic [7:0] OFS_LOW_ONE = 8'h0C;
    localparam logic [7:0] OFS_HIGH_TWO = 8'h10;
    localparam logic [7:0] OFS_LOW_TWO = 8'h14;
    localparam logic [7:0] OFS_COMMAND = 8'h18;
    localparam logic [7:0] OFS_INT_STATUS = 8'h1C;
    localparam logic [7:0] OFS_INT_MASK = 8'h20;

    // ************************************************************
    // Configuration fields, channel one first
    // ************************************************************
    localparam int CFG_POL_ONE = 7;
    localparam int CFG_MODE_ONE = 6;
    localparam int CFG_OVER_ONE = 5;
    localparam int CFG_UNDER_ONE = 4;
    localparam int CFG_POL_TWO = 3;
    localparam int CFG_MODE_TWO = 2;
    localparam int CFG_OVER_TWO = 1;
    localparam int CFG_UNDER_TWO = 0;
    localparam logic CFG_POL_RESET = 1'b0;
    localparam logic CFG_MODE_RESET = 1'b0;

    // ************************************************************
    // Commands and interrupt bits
    // ************************************************************
    localparam logic [7:0] CMD_CLEAR_ONE = 8'hB5;
    localparam logic [7:0] CMD_CLEAR_TWO = 8'h75;
    localparam int IRQ_CONV = 0;
    localparam int IRQ_TRIP_ONE = 1;
    localparam int IRQ_TRIP_TWO = 2;
    localparam int IRQ_W = 3;
    localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;

    localparam logic [DATA_W-1:0] LIMIT_OFF_HIGH = 16'h7FFC;
    localparam logic [DATA_W-1:0] LIMIT_OFF_LOW = 16'h8000;

    typedef struct packed {
        logic [DATA_W-1:0] high;
        logic [DATA_W-1:0] low;
    } limits_t;

    typedef struct packed {
        logic pol;
        logic therm;
    } chan_cfg_t;

endpackage : temp_alert_pkg

// file: verilog/alert_channel.sv
// Purpose: One alert channel: limit compare, flags, window/threshold mode.
// Assumes: conv_valid is a one-cycle pulse on pclk with result stable.
// Notes:   Clear is ignored in threshold mode.

`timescale 1ns/1ps

module alert_channel #(
    parameter int W = 16
) (
    input wire logic pclk, // Clock
    input wire logic presetn, // Async reset, active low
    input wire logic conv_valid, // New result pulse
    input wire logic signed [W-1:0] result, // Left-justified result
    input wire logic signed [W-1:0] high, // High limit
    input wire logic signed [W-1:0] low, // Low limit
    input wire logic therm_mode, // 1 threshold, 0 window
    input wire logic clear, // Release pulse, window mode only
    output logic over_limit_flag, // Over flag
    output logic under_limit_flag, // Under flag
    output logic alert // Channel active
);

    initial begin
        if (W < 2) begin
            $error("alert_channel: W too small");
        end
    end

    logic over_q, over_d, under_q, under_d;
    logic above, below;

    // ************************************************************
    // Compare and flag update
    // ************************************************************
    always_comb begin
        above = result > high;
        below = result < low;
        over_d = over_q;
        under_d = under_q;
        if (therm_mode) begin
            under_d = 1'b0;
            if (conv_valid) begin
                if (above) begin
                    over_d = 1'b1;
                end else if (below) begin
                    over_d = 1'b0;
                end
            end
        end else begin
            if (clear) begin
                over_d = 1'b0;
                under_d = 1'b0;
            end
            // A trip in the clearing cycle survives the clear
            if (conv_valid && above) begin
                over_d = 1'b1;
            end
            if (conv_valid && below) begin
                under_d = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            over_q <= 1'b0;
            under_q <= 1'b0;
        end else begin
            over_q <= over_d;
            under_q <= under_d;
        end
    end

    assign over_limit_flag = over_q;
    assign under_limit_flag = under_q;
    assign alert = over_q | under_q;

    // ************************************************************
    // Checks
    // ************************************************************
    sequence conv_above_s;
        conv_valid && (result > high);
    endsequence

    sequence conv_below_s;
        conv_valid && (result < low);
    endsequence

    over_trip_a: assert property (@(posedge pclk) disable iff (!presetn)
        conv_above_s |=> over_limit_flag && alert)
        else $error("over flag not set after high crossing");

    under_trip_a: assert property (@(posedge pclk) disable iff (!presetn)
        !therm_mode ##0 conv_below_s |=> under_limit_flag && alert)
        else $error("under flag not set after low crossing");

    window_latch_a: assert property (@(posedge pclk) disable iff (!presetn)
        (!therm_mode && alert && !clear) |=> alert)
        else $error("window alert dropped without clear");

    window_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        (!therm_mode && clear && !conv_valid) |=> !alert)
        else $error("window alert not released by clear");

    therm_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        (therm_mode && over_q && !(conv_valid && result < low))
        |=> over_q)
        else $error("threshold alert released early");

    therm_release_a: assert property (@(posedge pclk) disable iff (!presetn)
        therm_mode ##0 conv_below_s ##0 !(result > high)
        |=> !over_limit_flag)
        else $error("threshold alert not released below low");

    therm_under_a: assert property (@(posedge pclk) disable iff (!presetn)
        therm_mode |=> !under_limit_flag)
        else $error("under flag set in threshold mode");

    therm_noclr_a: assert property (@(posedge pclk) disable iff (!presetn)
        (therm_mode && clear && over_q && !conv_valid) |=> over_q)
        else $error("threshold alert cleared by clear");

endmodule : alert_channel

// file: verilog/temp_result_and_alert_compare.sv
// Purpose: Temperature result register and two-channel alert compare
//          with APB register access and an interrupt.
// Assumes: Conversion engine and nonvolatile defaults on the pclk domain.
// Notes:   Alarm pins are open drain: out is always 0, oe_n low drives.

`timescale 1ns/1ps

module temp_result_and_alert_compare (
    input wire logic pclk, // APB clock, 125 MHz
    input wire logic presetn, // Async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error, unmapped address
    input wire logic conv_valid, // Conversion done pulse
    input wire logic [temp_alert_pkg::TEMP_W-1:0] conv_data, // Result
    input wire temp_alert_pkg::limits_t nv_limits_one, // Default ch one
    input wire temp_alert_pkg::limits_t nv_limits_two, // Default ch two
    output logic alarm_out_one_o, // Pin one output value
    output logic alarm_out_one_oe_n, // Pin one enable, low drives
    output logic alarm_out_two_o, // Pin two output value
    output logic alarm_out_two_oe_n, // Pin two enable, low drives
    output logic irq // Level interrupt, active high
);

    localparam int DW = temp_alert_pkg::DATA_W;
    localparam int NCH = temp_alert_pkg::CHANNELS;
    localparam int IW = temp_alert_pkg::IRQ_W;

    // ************************************************************
    // State
    // ************************************************************
    logic [temp_alert_pkg::TEMP_W-1:0] temp_q, temp_d;
    temp_alert_pkg::limits_t [NCH-1:0] lim_q, lim_d;
    temp_alert_pkg::chan_cfg_t [NCH-1:0] cfg_q, cfg_d;
    logic [IW-1:0] status_q, status_d, mask_q, mask_d;
    logic [31:0] prdata_q, prdata_d;
    logic load_q, load_d;
    // Compare a cycle late so the channels see the newly stored result
    logic conv_q, conv_d;
    logic irq_q, irq_d;
    logic [NCH-1:0] alert_prev_q, alert_prev_d;
    logic [NCH-1:0] pin_low_q, pin_low_d;

    logic [NCH-1:0] over_flag, under_flag, alert, clear;
    logic [DW-1:0] result;
    logic setup, wr_acc, rd_acc, mapped;
    logic [7:0] cfg_rd;

    assign result = {temp_q, 2'b00};
    assign setup = psel && !penable;
    assign wr_acc = psel && penable && pwrite;
    assign rd_acc = psel && penable && !pwrite;

    // ************************************************************
    // Address decode
    // ************************************************************
    always_comb begin
        if (paddr == temp_alert_pkg::OFS_TEMP) begin
            mapped = 1'b1;
        end else if (paddr == temp_alert_pkg::OFS_CONFIG) begin
            mapped = 1'b1;
        end else if (paddr == temp_alert_pkg::OFS_HIGH_ONE) begin
            mapped = 1'b1;
        end else if (paddr == temp_alert_pkg::OFS_LOW_ONE) begin
            mapped = 1'b1;
        end else if (paddr == temp_alert_pkg::OFS_HIGH_TWO) begin
            mapped = 1'b1;
        end else if (paddr == temp_alert_pkg::OFS_LOW_TWO) begin
            mapped = 1'b1;
        end else if (paddr == temp_alert_pkg::OFS_COMMAND) begin
            mapped = 1'b1;
        end else if (paddr == temp_alert_pkg::OFS_INT_STATUS) begin
            mapped = 1'b1;
        end else if (paddr == temp_alert_pkg::OFS_INT_MASK) begin
            mapped = 1'b1;
        end else begin
            mapped = 1'b0;
        end
    end

    // Zero wait states: read data is captured in the setup cycle
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata = prdata_q;

    always_comb begin
        cfg_rd = 8'h00;
        cfg_rd[temp_alert_pkg::CFG_POL_ONE] = cfg_q[0].pol;
        cfg_rd[temp_alert_pkg::CFG_MODE_ONE] = cfg_q[0].therm;
        cfg_rd[temp_alert_pkg::CFG_OVER_ONE] = over_flag[0];
        cfg_rd[temp_alert_pkg::CFG_UNDER_ONE] = under_flag[0];
        cfg_rd[temp_alert_pkg::CFG_POL_TWO] = cfg_q[1].pol;
        cfg_rd[temp_alert_pkg::CFG_MODE_TWO] = cfg_q[1].therm;
        cfg_rd[temp_alert_pkg::CFG_OVER_TWO] = over_flag[1];
        cfg_rd[temp_alert_pkg::CFG_UNDER_TWO] = under_flag[1];
    end

    // ************************************************************
    // Register file and interrupt next state
    // ************************************************************
    always_comb begin
        temp_d = temp_q;
        lim_d = lim_q;
        cfg_d = cfg_q;
        status_d = status_q;
        mask_d = mask_q;
        prdata_d = prdata_q;
        load_d = 1'b0;
        conv_d = conv_valid;
        alert_prev_d = alert;
        // Disabled limits keep alert at 0, so the pin shows pol only
        for (int i = 0; i < NCH; i++) begin
            pin_low_d[i] = alert[i] ^ cfg_q[i].pol;
        end
        if (conv_valid) begin
            temp_d = conv_data;
        end
        if (setup && !pwrite) begin
            prdata_d = 32'h0000_0000;
            if (paddr == temp_alert_pkg::OFS_TEMP) begin
                // The low two bytes of the word carry the full result, the upper two read zero
                prdata_d[DW-1:0] = result;
            end else if (paddr == temp_alert_pkg::OFS_CONFIG) begin
                prdata_d[7:0] = cfg_rd;
            end else if (paddr == temp_alert_pkg::OFS_HIGH_ONE) begin
                prdata_d[DW-1:0] = lim_q[0].high;
            end else if (paddr == temp_alert_pkg::OFS_LOW_ONE) begin
                prdata_d[DW-1:0] = lim_q[0].low;
            end else if (paddr == temp_alert_pkg::OFS_HIGH_TWO) begin
                prdata_d[DW-1:0] = lim_q[1].high;
            end else if (paddr == temp_alert_pkg::OFS_LOW_TWO) begin
                prdata_d[DW-1:0] = lim_q[1].low;
            end else if (paddr == temp_alert_pkg::OFS_INT_STATUS) begin
                prdata_d[IW-1:0] = status_q;
            end else if (paddr == temp_alert_pkg::OFS_INT_MASK) begin
                prdata_d[IW-1:0] = mask_q;
            end
        end
        if (wr_acc) begin
            if (paddr == temp_alert_pkg::OFS_CONFIG) begin
                cfg_d[0].pol = pwdata[temp_alert_pkg::CFG_POL_ONE];
                cfg_d[0].therm = pwdata[temp_alert_pkg::CFG_MODE_ONE];
                cfg_d[1].pol = pwdata[temp_alert_pkg::CFG_POL_TWO];
                cfg_d[1].therm = pwdata[temp_alert_pkg::CFG_MODE_TWO];
            end else if (paddr == temp_alert_pkg::OFS_HIGH_ONE) begin
                lim_d[0].high = pwdata[DW-1:0];
            end else if (paddr == temp_alert_pkg::OFS_LOW_ONE) begin
                lim_d[0].low = pwdata[DW-1:0];
            end else if (paddr == temp_alert_pkg::OFS_HIGH_TWO) begin
                lim_d[1].high = pwdata[DW-1:0];
            end else if (paddr == temp_alert_pkg::OFS_LOW_TWO) begin
                lim_d[1].low = pwdata[DW-1:0];
            end else if (paddr == temp_alert_pkg::OFS_INT_STATUS) begin
                status_d = status_q & ~pwdata[IW-1:0];
            end else if (paddr == temp_alert_pkg::OFS_INT_MASK) begin
                mask_d = pwdata[IW-1:0];
            end
        end
        // Defaults load once after reset, ahead of any host write
        if (load_q) begin
            lim_d[0] = nv_limits_one;
            lim_d[1] = nv_limits_two;
        end
        // Events are applied after the clear so a set always wins
        if (conv_q) begin
            status_d[temp_alert_pkg::IRQ_CONV] = 1'b1;
        end
        if (alert[0] && !alert_prev_q[0]) begin
            status_d[temp_alert_pkg::IRQ_TRIP_ONE] = 1'b1;
        end
        if (alert[1] && !alert_prev_q[1]) begin
            status_d[temp_alert_pkg::IRQ_TRIP_TWO] = 1'b1;
        end
        irq_d = |(status_d & mask_d);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            temp_q <= '0;
            lim_q <= '0;
            cfg_q <= {NCH{temp_alert_pkg::CFG_POL_RESET,
                          temp_alert_pkg::CFG_MODE_RESET}};
            status_q <= temp_alert_pkg::IRQ_RESET;
            mask_q <= temp_alert_pkg::IRQ_RESET;
            prdata_q <= 32'h0000_0000;
            load_q <= 1'b1;
            conv_q <= 1'b0;
            pin_low_q <= '0;
            irq_q <= 1'b0;
            alert_prev_q <= '0;
        end else begin
            temp_q <= temp_d;
            lim_q <= lim_d;
            cfg_q <= cfg_d;
            status_q <= status_d;
            mask_q <= mask_d;
            prdata_q <= prdata_d;
            load_q <= load_d;
            conv_q <= conv_d;
            pin_low_q <= pin_low_d;
            irq_q <= irq_d;
            alert_prev_q <= alert_prev_d;
        end
    end

    assign irq = irq_q;

    // ************************************************************
    // Alert channels and pins
    // ************************************************************
    localparam logic [7:0] CLEAR_CMD [NCH] = '{temp_alert_pkg::CMD_CLEAR_ONE,
                                             temp_alert_pkg::CMD_CLEAR_TWO};

    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : gen_chan
            // Clear command, or any config read, releases the window alert
            assign clear[g] = (wr_acc && paddr == temp_alert_pkg::OFS_COMMAND
                && pwdata[7:0] == CLEAR_CMD[g])
                || (rd_acc && paddr == temp_alert_pkg::OFS_CONFIG);

            alert_channel #(
                .W(DW)
            ) u_chan (
                .pclk(pclk),
                .presetn(presetn),
                .conv_valid(conv_q),
                .result(result),
                .high(lim_q[g].high),
                .low(lim_q[g].low),
                .therm_mode(cfg_q[g].therm),
                .clear(clear[g]),
                .over_limit_flag(over_flag[g]),
                .under_limit_flag(under_flag[g]),
                .alert(alert[g])
            );

            pin_level_a: assert property (@(posedge pclk)
                disable iff (!presetn)
                (alert[g] && !cfg_q[g].pol) |=> pin_low_q[g])
                else $error("active alarm pin not driven low");

            trip_status_a: assert property (@(posedge pclk)
                disable iff (!presetn)
                (alert[g] && !alert_prev_q[g])
                |=> status_q[temp_alert_pkg::IRQ_TRIP_ONE + g])
                else $error("alarm trip status bit not set");

            pin_drive_a: assert property (@(posedge pclk)
                disable iff (!presetn)
                (alert[g] == cfg_q[g].pol) |=> !pin_low_q[g])
                else $error("pin driven while released");
        end
    endgenerate

    // Open drain: the pins only ever pull low
    assign alarm_out_one_o = 1'b0;
    assign alarm_out_two_o = 1'b0;
    assign alarm_out_one_oe_n = !pin_low_q[0];
    assign alarm_out_two_oe_n = !pin_low_q[1];

    // ************************************************************
    // Checks
    // ************************************************************
    result_store_a: assert property (@(posedge pclk) disable iff (!presetn)
        conv_valid |=> temp_q == $past(conv_data))
        else $error("conversion result not stored");

    nv_load_a: assert property (@(posedge pclk) disable iff (!presetn)
        load_q |=> (lim_q[0] == $past(nv_limits_one))
        && (lim_q[1] == $past(nv_limits_two)))
        else $error("nonvolatile limits not loaded");

    temp_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        (setup && !pwrite && paddr == temp_alert_pkg::OFS_TEMP)
        |=> prdata[DW-1:0] == $past(result))
        else $error("temperature read data wrong");

    irq_level_a: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 irq == |(status_q & mask_q))
        else $error("interrupt level disagrees with status");

    open_drain_a: assert property (@(posedge pclk) disable iff (!presetn)
        !alarm_out_one_o && !alarm_out_two_o)
        else $error("alarm pin driven high");

    fresh_compare_a: assert property (@(posedge pclk) disable iff (!presetn)
        conv_q |-> result == {$past(conv_data), 2'b00})
        else $error("compare did not use the new result");

    conv_status_a: assert property (@(posedge pclk) disable iff (!presetn)
        conv_q |=> status_q[temp_alert_pkg::IRQ_CONV])
        else $error("conversion status bit not set");

    status_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_acc && paddr == temp_alert_pkg::OFS_INT_STATUS
        && pwdata[temp_alert_pkg::IRQ_CONV] && !conv_q)
        |=> !status_q[temp_alert_pkg::IRQ_CONV])
        else $error("conversion status not cleared by a one");

endmodule : temp_result_and_alert_compare

// file: verif/alarm_pullup.sv
// Purpose: Board side of one open-drain alarm pin, with its pull-up.
// Assumes: The pin enable is low while the device drives the pin.
// Notes:   A released pin reads high, never the last driven value.

`timescale 1ns/1ps

module alarm_pullup (
    input wire logic o, // Driven value
    input wire logic oe_n, // Enable, low drives
    output logic pin // Resolved pin level
);
    assign pin = oe_n ? 1'b1 : o;
endmodule : alarm_pullup

// file: verif/tb_top.sv
// Purpose: Self-checking bench for the result and alarm compare block.
// Assumes: Zero-wait APB slave, pins resolved by pull-up models.
// Notes:   Pin checks settle two edges and sample on the falling edge.

`timescale 1ns/1ps

module tb_top;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic conv_valid, o1, oe1, o2, oe2, pin1, pin2, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [13:0] conv_data;
    int fail_count = 0;
    int checks = 0;
    int cyc = 0;
    temp_alert_pkg::limits_t nv1, nv2;
    assign nv1 = {16'h6400, 16'h1900};
    assign nv2 = {16'h3200, 16'h1000};

    temp_result_and_alert_compare u_dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .conv_valid(conv_valid), .conv_data(conv_data),
        .nv_limits_one(nv1), .nv_limits_two(nv2), .alarm_out_one_o(o1),
        .alarm_out_one_oe_n(oe1), .alarm_out_two_o(o2),
        .alarm_out_two_oe_n(oe2), .irq(irq));
    alarm_pullup u_pu1 (.o(o1), .oe_n(oe1), .pin(pin1));
    alarm_pullup u_pu2 (.o(o2), .oe_n(oe2), .pin(pin2));

    // ****************************************************************
    // Tasks
    // ****************************************************************
    task complete_run;
        if (fail_count == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : complete_run

    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            fail_count++;
            $display("FAIL %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task rw(input logic [7:0] a, input logic w, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // One idle edge, so a following call never drives psel twice at once
        @(posedge pclk);
    endtask : rw

    task wr(input logic [7:0] a, input logic [31:0] d);
        rw(a, 1'b1, d);
    endtask : wr

    task rdc(input logic [7:0] a, input logic [31:0] e);
        rw(a, 1'b0, 32'h0000_0000);
        chk("read", e, rd);
    endtask : rdc

    task conv(input logic [13:0] d);
        conv_data <= d;
        conv_valid <= 1'b1;
        @(posedge pclk);
        conv_valid <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask : conv

    task pins(input logic e1, input logic e2, input logic ei);
        repeat (2) @(posedge pclk);
        @(negedge pclk);
        chk("pin1", {31'h0, e1}, {31'h0, pin1});
        chk("pin2", {31'h0, e2}, {31'h0, pin2});
        chk("irq", {31'h0, ei}, {31'h0, irq});
        @(posedge pclk);
    endtask : pins

    // ****************************************************************
    // Clock, timeout and sequence
    // ****************************************************************
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    // Whole sequence needs well under a thousand cycles
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            fail_count++;
            complete_run();
        end
    end

    initial begin
        {presetn, psel, penable, pwrite, conv_valid} = 5'h00;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        conv_data = 14'h0000;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        pins(1'b1, 1'b1, 1'b0);
        rdc(8'h08, 32'h0000_6400);
        wr(8'h10, 32'h0000_4000);
        rdc(8'h10, 32'h0000_4000);
        wr(8'h20, 32'h0000_0007);
        conv(14'h1FFF);
        rdc(8'h00, 32'h0000_7FFC);
        pins(1'b0, 1'b0, 1'b1);
        rdc(8'h1C, 32'h0000_0007);
        wr(8'h18, 32'h0000_00B5);
        pins(1'b1, 1'b0, 1'b1);
        rdc(8'h04, 32'h0000_0002);
        pins(1'b1, 1'b1, 1'b1);
        wr(8'h1C, 32'h0000_0007);
        pins(1'b1, 1'b1, 1'b0);
        wr(8'h20, 32'h0000_0000);
        wr(8'h04, 32'h0000_0004);
        conv(14'h1FFF);
        pins(1'b0, 1'b0, 1'b0);
        rdc(8'h04, 32'h0000_0026);
        pins(1'b1, 1'b0, 1'b0);
        wr(8'h18, 32'h0000_0075);
        pins(1'b1, 1'b0, 1'b0);
        conv(14'h0C80);
        pins(1'b1, 1'b0, 1'b0);
        conv(14'h0010);
        pins(1'b0, 1'b1, 1'b0);
        rdc(8'h04, 32'h0000_0014);
        wr(8'h08, 32'h0000_7FFC);
        wr(8'h0C, 32'h0000_8000);
        wr(8'h04, 32'h0000_008C);
        conv(14'h1FFF);
        pins(1'b0, 1'b1, 1'b0);
        conv(14'h3240);
        rdc(8'h00, 32'h0000_C900);
        pins(1'b0, 1'b0, 1'b0);
        wr(8'h10, 32'h0000_1234);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        rdc(8'h10, 32'h0000_3200);
        rdc(8'h04, 32'h0000_0000);
        pins(1'b1, 1'b1, 1'b0);
        rw(8'h40, 1'b0, 32'h0000_0000);
        chk("pslverr", 32'h0000_0001, {31'h0, err});
        chk("unmapped", 32'h0000_0000, rd);
        complete_run();
    end
endmodule : tb_top
